// >>> core/cbt_core.sv
// Decided for this implementation: the APB interface to the registers and the address map.
module cbt_core (
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [cbt_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic bus_receive_pin,
	output logic bus_transmit_pin,
	input wire logic tx_bit,
	output logic rx_bit,
	output logic sample_pulse,
	output logic bit_start,
	output logic comm_active,
	output logic can_clk_en,
	output logic [15:0] timestamp,
	input wire logic debug_active,
	input wire logic debug_pause_system
);
	typedef struct packed {
		logic rx_meta;
		logic rx_sync;
		logic rx_prev;
		cbt_pkg::cbt_mode_e mode;
		cbt_pkg::cbt_phase_e phase;
		logic [11:0] tq_cnt;
		logic [4:0] seg_cnt;
		logic [2:0] seg_ext;
		logic [2:0] seg_short;
		logic resynced;
		logic [3:0] rec_cnt;
		logic [15:0] timer;
		logic [15:0] stamp;
		cbt_pkg::cbt_ctrl_s ctrl;
		cbt_pkg::cbt_timing_s timing;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic tx_pin;
		logic rx_bit;
		logic sample;
		logic bit_start;
		logic clk_en;
		logic comm;
	} cbt_state_s;

	cbt_state_s st_q;
	cbt_state_s st_d;

	logic running;
	logic halt;
	logic rx_src;
	logic fall;
	logic idle;
	logic tq_tick;
	logic [2:0] sjw1;
	logic [4:0] len1;
	logic [4:0] len2_base;
	logic [4:0] len2;
	logic [4:0] remain;
	logic wr_hs;
	logic rd_acc;
	logic [31:0] mc_rd;
	logic [31:0] ms_rd;
	logic [31:0] cap_rd;

	always_comb begin
		halt = debug_active && (debug_pause_system || st_q.ctrl.debug_pause_local);
		running = ((st_q.mode == cbt_pkg::MODE_SYNC) || (st_q.mode == cbt_pkg::MODE_COMM)) && !halt;
		// Receive source by test mode
		if (st_q.timing.loopback_enable) begin
			rx_src = tx_bit;
		end else if (st_q.timing.listen_only_enable) begin
			rx_src = st_q.rx_sync && tx_bit;
		end else begin
			rx_src = st_q.rx_sync;
		end
		fall = st_q.rx_prev && !rx_src;
		idle = (st_q.rec_cnt == cbt_pkg::IDLE_BITS);
		tq_tick = (st_q.tq_cnt == st_q.timing.baud_prescaler);
		sjw1 = {1'b0, st_q.timing.resync_jump_width} + 3'h1;
		len1 = {1'b0, st_q.timing.segment_one_length} + 5'h01 + {2'b00, st_q.seg_ext};
		len2_base = {2'b00, st_q.timing.segment_two_length} + 5'h01;
		len2 = len2_base - {2'b00, st_q.seg_short};
		remain = len2_base - st_q.seg_cnt;
		wr_hs = psel && penable && st_q.pready && pwrite;
		rd_acc = psel && penable && !st_q.pready;
		mc_rd = 32'h0000_0000;
		mc_rd[cbt_pkg::MC_FREEZE_BIT] = st_q.ctrl.freeze_request;
		mc_rd[cbt_pkg::MC_SLEEP_BIT] = st_q.ctrl.sleep_request;
		mc_rd[cbt_pkg::MC_TTC_BIT] = st_q.ctrl.time_triggered_enable;
		mc_rd[cbt_pkg::MC_AWU_BIT] = st_q.ctrl.auto_wakeup_enable;
		mc_rd[cbt_pkg::MC_DBG_BIT] = st_q.ctrl.debug_pause_local;
		ms_rd = 32'h0000_0000;
		ms_rd[cbt_pkg::MS_FREEZE_ACK_BIT] = (st_q.mode == cbt_pkg::MODE_FROZEN);
		ms_rd[cbt_pkg::MS_SLEEP_ACK_BIT] = (st_q.mode == cbt_pkg::MODE_SLEEP);
		ms_rd[cbt_pkg::MS_COMM_BIT] = (st_q.mode == cbt_pkg::MODE_COMM);
		ms_rd[cbt_pkg::MS_RX_BIT] = st_q.rx_bit;
		cap_rd = 32'h0000_0000;
		cap_rd[cbt_pkg::CAP_BANKS_LSB +: 8] = cbt_pkg::NUM_FILTER_BANKS;
		cap_rd[cbt_pkg::CAP_FIFOS_LSB +: 4] = cbt_pkg::NUM_RX_FIFOS;
		cap_rd[cbt_pkg::CAP_DEPTH_LSB +: 4] = cbt_pkg::RX_FIFO_DEPTH;
		cap_rd[cbt_pkg::CAP_MBOX_LSB +: 4] = cbt_pkg::NUM_TX_MAILBOXES;
		cap_rd[cbt_pkg::CAP_EXT_ID_BIT] = 1'b1;
	end

	always_comb begin
		st_d = st_q;
		st_d.rx_meta = bus_receive_pin;
		st_d.rx_sync = st_q.rx_meta;
		st_d.rx_prev = rx_src;
		st_d.sample = 1'b0;
		st_d.bit_start = 1'b0;

		// Bit timing: quantum prescaler and segments
		if (running) begin
			if (fall && idle) begin
				// Start of frame: restart bit with the edge in sync segment
				st_d.phase = cbt_pkg::PH_SEG1;
				st_d.tq_cnt = 12'h000;
				st_d.seg_cnt = 5'h00;
				st_d.seg_ext = 3'h0;
				st_d.seg_short = 3'h0;
				st_d.resynced = 1'b0;
				st_d.rec_cnt = 4'h0;
				st_d.stamp = st_q.timer;
			end else if (fall && !st_q.resynced && st_q.phase == cbt_pkg::PH_SEG1) begin
				// Late edge: lengthen segment one, bounded by jump width
				st_d.resynced = 1'b1;
				st_d.seg_ext = (st_q.seg_cnt < {2'b00, sjw1}) ? st_q.seg_cnt[2:0] : sjw1;
			end else if (fall && !st_q.resynced && st_q.phase == cbt_pkg::PH_SEG2) begin
				// Early edge: shorten segment two or end the bit here
				if (remain <= {2'b00, sjw1}) begin
					st_d.phase = cbt_pkg::PH_SEG1;
					st_d.tq_cnt = 12'h000;
					st_d.seg_cnt = 5'h00;
					st_d.seg_ext = 3'h0;
					st_d.seg_short = 3'h0;
					st_d.resynced = 1'b1;
					st_d.bit_start = 1'b1;
					if (st_q.ctrl.time_triggered_enable) begin
						st_d.timer = st_q.timer + 16'h0001;
					end
				end else begin
					st_d.seg_short = sjw1;
					st_d.resynced = 1'b1;
				end
			end else if (tq_tick) begin
				st_d.tq_cnt = 12'h000;
				case (st_q.phase)
					cbt_pkg::PH_SYNC: begin
						st_d.phase = cbt_pkg::PH_SEG1;
						st_d.seg_cnt = 5'h00;
					end
					cbt_pkg::PH_SEG1: begin
						if (st_q.seg_cnt == len1 - 5'h01) begin
							st_d.phase = cbt_pkg::PH_SEG2;
							st_d.seg_cnt = 5'h00;
							st_d.sample = 1'b1;
							st_d.rx_bit = rx_src;
							if (!rx_src) begin
								st_d.rec_cnt = 4'h0;
							end else if (!idle) begin
								st_d.rec_cnt = st_q.rec_cnt + 4'h1;
							end
						end else begin
							st_d.seg_cnt = st_q.seg_cnt + 5'h01;
						end
					end
					cbt_pkg::PH_SEG2: begin
						if (st_q.seg_cnt >= len2 - 5'h01) begin
							st_d.phase = cbt_pkg::PH_SYNC;
							st_d.seg_cnt = 5'h00;
							st_d.seg_ext = 3'h0;
							st_d.seg_short = 3'h0;
							st_d.resynced = 1'b0;
							st_d.bit_start = 1'b1;
							if (st_q.ctrl.time_triggered_enable) begin
								st_d.timer = st_q.timer + 16'h0001;
							end
						end else begin
							st_d.seg_cnt = st_q.seg_cnt + 5'h01;
						end
					end
					default: begin
						st_d.phase = cbt_pkg::PH_SYNC;
					end
				endcase
			end else begin
				st_d.tq_cnt = st_q.tq_cnt + 12'h001;
			end
		end

		// Operating mode sequencing
		case (st_q.mode)
			cbt_pkg::MODE_SLEEP: begin
				if (st_q.ctrl.auto_wakeup_enable && fall) begin
					st_d.ctrl.sleep_request = 1'b0;
				end
				if (!st_q.ctrl.sleep_request) begin
					st_d.mode = st_q.ctrl.freeze_request ? cbt_pkg::MODE_FROZEN
						: cbt_pkg::MODE_SYNC;
				end
			end
			cbt_pkg::MODE_FROZEN: begin
				if (st_q.ctrl.sleep_request && !st_q.ctrl.freeze_request) begin
					st_d.mode = cbt_pkg::MODE_SLEEP;
				end else if (!st_q.ctrl.freeze_request && !st_q.ctrl.sleep_request) begin
					st_d.mode = cbt_pkg::MODE_SYNC;
				end
			end
			cbt_pkg::MODE_SYNC: begin
				if (st_q.ctrl.freeze_request) begin
					st_d.mode = cbt_pkg::MODE_FROZEN;
				end else if (st_q.ctrl.sleep_request) begin
					st_d.mode = cbt_pkg::MODE_SLEEP;
				end else if (idle) begin
					st_d.mode = cbt_pkg::MODE_COMM;
				end
			end
			cbt_pkg::MODE_COMM: begin
				if (idle && st_q.ctrl.freeze_request) begin
					st_d.mode = cbt_pkg::MODE_FROZEN;
				end else if (idle && st_q.ctrl.sleep_request) begin
					st_d.mode = cbt_pkg::MODE_SLEEP;
				end
			end
			default: begin
				st_d.mode = cbt_pkg::MODE_SLEEP;
			end
		endcase
		if (st_d.mode != cbt_pkg::MODE_SYNC && st_d.mode != cbt_pkg::MODE_COMM) begin
			// Bit timing restarts from a clean bit on the next synchronisation
			st_d.phase = cbt_pkg::PH_SYNC;
			st_d.tq_cnt = 12'h000;
			st_d.seg_cnt = 5'h00;
			st_d.seg_ext = 3'h0;
			st_d.seg_short = 3'h0;
			st_d.resynced = 1'b0;
			st_d.rec_cnt = 4'h0;
			st_d.rx_bit = 1'b1;
		end
		st_d.clk_en = (st_d.mode != cbt_pkg::MODE_SLEEP);
		st_d.comm = (st_d.mode == cbt_pkg::MODE_COMM);
		if (st_d.mode == cbt_pkg::MODE_COMM && !st_q.timing.listen_only_enable) begin
			st_d.tx_pin = tx_bit;
		end else begin
			st_d.tx_pin = 1'b1;
		end

		// APB slave, one wait state
		st_d.pready = rd_acc;
		if (rd_acc) begin
			st_d.pslverr = 1'b0;
			case (paddr)
				cbt_pkg::MASTER_CONTROL_OFS: st_d.prdata = mc_rd;
				cbt_pkg::MASTER_STATUS_OFS: st_d.prdata = ms_rd;
				cbt_pkg::BIT_TIMING_OFS: st_d.prdata = {st_q.timing.listen_only_enable,
					st_q.timing.loopback_enable, 4'h0, st_q.timing.resync_jump_width,
					1'b0, st_q.timing.segment_two_length, st_q.timing.segment_one_length,
					4'h0, st_q.timing.baud_prescaler};
				cbt_pkg::TIMER_OFS: st_d.prdata = {st_q.stamp, st_q.timer};
				cbt_pkg::CAPABILITY_OFS: st_d.prdata = cap_rd;
				default: begin
					st_d.prdata = 32'h0000_0000;
					st_d.pslverr = 1'b1;
				end
			endcase
		end else if (!st_q.pready) begin
			st_d.prdata = 32'h0000_0000;
			st_d.pslverr = 1'b0;
		end
		if (wr_hs && paddr == cbt_pkg::MASTER_CONTROL_OFS) begin
			// Software write lands after any hardware clear, so a set wins
			st_d.ctrl.freeze_request = pwdata[cbt_pkg::MC_FREEZE_BIT];
			st_d.ctrl.sleep_request = pwdata[cbt_pkg::MC_SLEEP_BIT];
			st_d.ctrl.time_triggered_enable = pwdata[cbt_pkg::MC_TTC_BIT];
			st_d.ctrl.auto_wakeup_enable = pwdata[cbt_pkg::MC_AWU_BIT];
			st_d.ctrl.debug_pause_local = pwdata[cbt_pkg::MC_DBG_BIT];
		end
		if (wr_hs && paddr == cbt_pkg::BIT_TIMING_OFS && st_q.mode == cbt_pkg::MODE_FROZEN) begin
			st_d.timing.baud_prescaler = pwdata[cbt_pkg::BT_PRESC_LSB +: 12];
			st_d.timing.segment_one_length = pwdata[cbt_pkg::BT_SEG1_LSB +: 4];
			st_d.timing.segment_two_length = pwdata[cbt_pkg::BT_SEG2_LSB +: 3];
			st_d.timing.resync_jump_width = pwdata[cbt_pkg::BT_SJW_LSB +: 2];
			st_d.timing.loopback_enable = pwdata[cbt_pkg::BT_LOOP_BIT];
			st_d.timing.listen_only_enable = pwdata[cbt_pkg::BT_LISTEN_BIT];
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			st_q <= '0;
			st_q.rx_meta <= 1'b1;
			st_q.rx_sync <= 1'b1;
			st_q.rx_prev <= 1'b1;
			st_q.mode <= cbt_pkg::MODE_SLEEP;
			st_q.phase <= cbt_pkg::PH_SYNC;
			st_q.ctrl.freeze_request <= cbt_pkg::MC_RESET[cbt_pkg::MC_FREEZE_BIT];
			st_q.ctrl.sleep_request <= cbt_pkg::MC_RESET[cbt_pkg::MC_SLEEP_BIT];
			st_q.ctrl.time_triggered_enable <= cbt_pkg::MC_RESET[cbt_pkg::MC_TTC_BIT];
			st_q.ctrl.auto_wakeup_enable <= cbt_pkg::MC_RESET[cbt_pkg::MC_AWU_BIT];
			st_q.ctrl.debug_pause_local <= cbt_pkg::MC_RESET[cbt_pkg::MC_DBG_BIT];
			st_q.timing.listen_only_enable <= cbt_pkg::BT_RESET[cbt_pkg::BT_LISTEN_BIT];
			st_q.timing.loopback_enable <= cbt_pkg::BT_RESET[cbt_pkg::BT_LOOP_BIT];
			st_q.timing.resync_jump_width <= cbt_pkg::BT_RESET[cbt_pkg::BT_SJW_LSB +: 2];
			st_q.timing.segment_two_length <= cbt_pkg::BT_RESET[cbt_pkg::BT_SEG2_LSB +: 3];
			st_q.timing.segment_one_length <= cbt_pkg::BT_RESET[cbt_pkg::BT_SEG1_LSB +: 4];
			st_q.timing.baud_prescaler <= cbt_pkg::BT_RESET[cbt_pkg::BT_PRESC_LSB +: 12];
			st_q.tx_pin <= 1'b1;
			st_q.rx_bit <= 1'b1;
		end else begin
			st_q <= st_d;
		end
	end

	// Guards on bit timing and mode sequencing
	AST_TQ_BOUND: assert property (@(posedge mclk) disable iff (!arst_n)
		st_q.tq_cnt <= st_q.timing.baud_prescaler)
		else $error("Quantum counter beyond prescaler");
	AST_SAMPLE_POINT: assert property (@(posedge mclk) disable iff (!arst_n)
		st_q.sample |-> st_q.phase == cbt_pkg::PH_SEG2)
		else $error("Sample pulse outside segment boundary");
	AST_JUMP_WIDTH: assert property (@(posedge mclk) disable iff (!arst_n)
		st_q.seg_ext <= sjw1 && st_q.seg_short <= sjw1)
		else $error("Phase correction beyond jump width");
	AST_SLEEP_CLOCK: assert property (@(posedge mclk) disable iff (!arst_n)
		st_q.mode == cbt_pkg::MODE_SLEEP |-> !st_q.clk_en)
		else $error("Clock enabled in sleep");
	AST_COMM_AFTER_IDLE: assert property (@(posedge mclk) disable iff (!arst_n)
		$rose(st_q.comm) |-> $past(st_q.rec_cnt) == cbt_pkg::IDLE_BITS)
		else $error("Communication entered without bus idle");
	AST_FROZEN_SILENT: assert property (@(posedge mclk) disable iff (!arst_n)
		st_q.mode == cbt_pkg::MODE_FROZEN |-> st_q.tx_pin && st_q.rx_bit)
		else $error("Frozen node drives the bus");
	AST_REQ_WAITS: assert property (@(posedge mclk) disable iff (!arst_n)
		st_q.mode == cbt_pkg::MODE_COMM && !idle |=> st_q.mode == cbt_pkg::MODE_COMM)
		else $error("Mode left during transmission");
	AST_LISTEN_RECESSIVE: assert property (@(posedge mclk) disable iff (!arst_n)
		st_q.timing.listen_only_enable |-> st_q.tx_pin)
		else $error("Listen-only node drives dominant");

	assign prdata = st_q.prdata;
	assign pready = st_q.pready;
	assign pslverr = st_q.pslverr;
	assign bus_transmit_pin = st_q.tx_pin;
	assign rx_bit = st_q.rx_bit;
	assign sample_pulse = st_q.sample;
	assign bit_start = st_q.bit_start;
	assign comm_active = st_q.comm;
	assign can_clk_en = st_q.clk_en;
	assign timestamp = st_q.stamp;
endmodule // cbt_core

// >>> core/cbt_pkg.sv
package cbt_pkg;
	localparam int ADDR_W = 12;
	// Register byte offsets
	localparam logic [11:0] MASTER_CONTROL_OFS = 12'h000;
	localparam logic [11:0] MASTER_STATUS_OFS = 12'h004;
	localparam logic [11:0] BIT_TIMING_OFS = 12'h008;
	localparam logic [11:0] TIMER_OFS = 12'h00c;
	localparam logic [11:0] CAPABILITY_OFS = 12'h010;
	// master_control_reg fields
	localparam int MC_FREEZE_BIT = 0;
	localparam int MC_SLEEP_BIT = 1;
	localparam int MC_TTC_BIT = 2;
	localparam int MC_AWU_BIT = 3;
	localparam int MC_DBG_BIT = 4;
	localparam logic [31:0] MC_RESET = 32'h0000_0002;
	// master_status_reg fields
	localparam int MS_FREEZE_ACK_BIT = 0;
	localparam int MS_SLEEP_ACK_BIT = 1;
	localparam int MS_COMM_BIT = 2;
	localparam int MS_RX_BIT = 3;
	// bit_timing_reg fields
	localparam int BT_PRESC_LSB = 0;
	localparam int BT_SEG1_LSB = 16;
	localparam int BT_SEG2_LSB = 20;
	localparam int BT_SJW_LSB = 24;
	localparam int BT_LOOP_BIT = 30;
	localparam int BT_LISTEN_BIT = 31;
	localparam logic [31:0] BT_RESET = 32'h0000_0000;
	// Capability fields and values
	localparam int CAP_BANKS_LSB = 0;
	localparam int CAP_FIFOS_LSB = 8;
	localparam int CAP_DEPTH_LSB = 12;
	localparam int CAP_MBOX_LSB = 16;
	localparam int CAP_EXT_ID_BIT = 20;
	localparam logic [7:0] NUM_FILTER_BANKS = 8'h0e;
	localparam logic [3:0] NUM_RX_FIFOS = 4'h2;
	localparam logic [3:0] RX_FIFO_DEPTH = 4'h3;
	localparam logic [3:0] NUM_TX_MAILBOXES = 4'h3;
	// Recessive bits needed for bus idle
	localparam logic [3:0] IDLE_BITS = 4'hb;

	typedef enum logic [1:0] {MODE_SLEEP, MODE_FROZEN, MODE_SYNC, MODE_COMM} cbt_mode_e;
	typedef enum logic [1:0] {PH_SYNC, PH_SEG1, PH_SEG2} cbt_phase_e;

	typedef struct packed {
		logic listen_only_enable;
		logic loopback_enable;
		logic [1:0] resync_jump_width;
		logic [2:0] segment_two_length;
		logic [3:0] segment_one_length;
		logic [11:0] baud_prescaler;
	} cbt_timing_s;

	typedef struct packed {
		logic freeze_request;
		logic sleep_request;
		logic time_triggered_enable;
		logic auto_wakeup_enable;
		logic debug_pause_local;
	} cbt_ctrl_s;
endpackage

// >>> verification/cbt_bus_node.sv
module cbt_bus_node (
	input wire logic node_tx,
	input wire logic hold_dominant,
	output logic bus_level
);
	timeunit 1ns;
	timeprecision 1ps;
	// Wired-AND bus, recessive while nobody drives dominant
	always_comb bus_level = node_tx & ~hold_dominant;
endmodule // cbt_bus_node

// >>> verification/testbench.sv
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [11:0] MC = cbt_pkg::MASTER_CONTROL_OFS;
	localparam logic [11:0] MS = cbt_pkg::MASTER_STATUS_OFS;
	localparam logic [11:0] BT = cbt_pkg::BIT_TIMING_OFS;
	// Quantum 2 clocks, segment one 3 quanta, segment two 2 quanta
	localparam logic [31:0] BT0 = 32'h0012_0001;
	logic mclk, arst_n, psel, penable, pwrite, tx_bit, dbg, dbg_sys, dom, perr;
	logic pready, pslverr, txp, rxp, rx_bit, sample_pulse, bit_start, comm_active, can_clk_en;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [15:0] timestamp, t0;
	int failures, samples_checked, n;
	realtime ts;

	cbt_core u_dut (.mclk(mclk), .arst_n(arst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .bus_receive_pin(rxp), .bus_transmit_pin(txp), .tx_bit(tx_bit),
		.rx_bit(rx_bit), .sample_pulse(sample_pulse), .bit_start(bit_start),
		.comm_active(comm_active), .can_clk_en(can_clk_en), .timestamp(timestamp),
		.debug_active(dbg), .debug_pause_system(dbg_sys));
	cbt_bus_node u_node (.node_tx(txp), .hold_dominant(dom), .bus_level(rxp));

	initial begin
		mclk = 0;
		forever #5 mclk = ~mclk;
	end

	task automatic report_and_stop;
		$display("failures=%0d samples_checked=%0d", failures, samples_checked);
		if (failures == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int k;
		@(posedge mclk);
		psel <= 1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1;
		k = 0;
		do begin
			@(posedge mclk);
			k++;
		end while (pready !== 1'b1 && k < 64);
		rd = prdata;
		perr = pslverr;
		psel <= 0;
		penable <= 0;
	endtask

	task automatic wait_stat(input int b, input logic v);
		int k;
		k = 0;
		do begin
			apb(0, MS, 0);
			k++;
		end while (rd[b] !== v && k < 400);
		chk(rd[b], v);
	endtask

	task automatic next_evt(input logic smp, output int c);
		c = 0;
		do begin
			@(posedge mclk);
			c++;
		end while ((smp ? sample_pulse : bit_start) !== 1'b1 && c < 3000);
	endtask

	task automatic count_bits(input int cyc, output int c);
		c = 0;
		repeat (cyc) begin
			@(posedge mclk);
			if (bit_start === 1'b1) c++;
		end
	endtask

	// No mailbox or filter register is ever written by the bench
	task automatic to_comm(input logic [31:0] bt, input logic [31:0] mc);
		apb(1, MC, 32'h1);
		wait_stat(cbt_pkg::MS_FREEZE_ACK_BIT, 1);
		apb(1, BT, bt);
		apb(1, MC, mc);
		wait_stat(cbt_pkg::MS_COMM_BIT, 1);
	endtask

	task automatic t_reset_caps;
		apb(0, MC, 0);
		chk(rd, cbt_pkg::MC_RESET);
		apb(0, BT, 0);
		chk(rd, cbt_pkg::BT_RESET);
		apb(0, MS, 0);
		chk(rd[cbt_pkg::MS_SLEEP_ACK_BIT], 1);
		chk(can_clk_en, 0);
		apb(0, cbt_pkg::CAPABILITY_OFS, 0);
		chk(rd[20:0], {1'b1, cbt_pkg::NUM_TX_MAILBOXES, cbt_pkg::RX_FIFO_DEPTH,
			cbt_pkg::NUM_RX_FIFOS, cbt_pkg::NUM_FILTER_BANKS});
		apb(1, 12'h100, 32'hffff_ffff);
		chk(perr, 1);
		apb(0, MC, 0);
		chk(rd, cbt_pkg::MC_RESET);
		chk(perr, 0);
	endtask

	task automatic t_freeze_timing;
		apb(1, MC, 32'h1);
		wait_stat(cbt_pkg::MS_FREEZE_ACK_BIT, 1);
		chk(rd[cbt_pkg::MS_SLEEP_ACK_BIT], 0);
		chk(can_clk_en, 1);
		apb(1, BT, BT0);
		apb(0, BT, 0);
		chk(rd, BT0);
		tx_bit <= 0;
		repeat (30) @(posedge mclk);
		chk(txp, 1);
		tx_bit <= 1;
		dom <= 1;
		apb(1, MC, 0);
		repeat (300) @(posedge mclk);
		apb(0, MS, 0);
		chk(rd[cbt_pkg::MS_COMM_BIT], 0);
		dom <= 0;
		ts = $realtime;
		wait_stat(cbt_pkg::MS_COMM_BIT, 1);
		chk(($realtime - ts) >= 1200.0, 1);
		chk(($realtime - ts) <= 1560.0, 1);
		chk(rd[cbt_pkg::MS_FREEZE_ACK_BIT], 0);
		chk(comm_active, 1);
		next_evt(0, n);
		next_evt(0, n);
		chk(n, 12);
		next_evt(1, n);
		chk(n, 8);
	endtask

	task automatic t_timer_debug;
		to_comm(BT0, 32'h4);
		next_evt(0, n);
		apb(0, cbt_pkg::TIMER_OFS, 0);
		t0 = rd[15:0];
		repeat (5) next_evt(0, n);
		apb(0, cbt_pkg::TIMER_OFS, 0);
		chk(32'(rd[15:0] - t0), 5);
		dbg <= 1;
		dbg_sys <= 1;
		count_bits(60, n);
		chk(n, 0);
		dbg_sys <= 0;
		count_bits(48, n);
		chk(n, 4);
		apb(1, MC, 32'h14);
		count_bits(60, n);
		chk(n, 0);
		dbg <= 0;
		count_bits(48, n);
		chk(n, 4);
	endtask

	task automatic t_test_modes;
		logic [1:0] m;
		for (int i = 3; i >= 0; i--) begin
			m = 2'(i);
			to_comm(BT0 | {m, 30'h0}, 0);
			apb(0, cbt_pkg::TIMER_OFS, 0);
			t0 = rd[15:0];
			tx_bit <= 0;
			next_evt(0, n);
			next_evt(0, n);
			chk(txp, m[1]);
			chk(rx_bit, 0);
			chk({16'h0000, timestamp}, {16'h0000, t0});
			tx_bit <= 1;
			dom <= 1;
			next_evt(0, n);
			next_evt(0, n);
			chk(txp, 1);
			chk(rx_bit, m[0]);
			dom <= 0;
		end
	endtask

	task automatic t_sleep;
		apb(1, MC, 32'ha);
		wait_stat(cbt_pkg::MS_SLEEP_ACK_BIT, 1);
		chk(can_clk_en, 0);
		dom <= 1;
		n = 0;
		do begin
			apb(0, MC, 0);
			n++;
		end while (rd[cbt_pkg::MC_SLEEP_BIT] !== 1'b0 && n < 400);
		chk(rd[cbt_pkg::MC_SLEEP_BIT], 0);
		dom <= 0;
		apb(1, MC, 32'h2);
		wait_stat(cbt_pkg::MS_SLEEP_ACK_BIT, 1);
		apb(1, MC, 32'h0);
		wait_stat(cbt_pkg::MS_SLEEP_ACK_BIT, 0);
	endtask

	initial begin
		arst_n = 0;
		{psel, penable, pwrite, dbg, dbg_sys, dom} = '0;
		tx_bit = 1;
		paddr = '0;
		pwdata = '0;
		failures = 0;
		samples_checked = 0;
		repeat (3) @(posedge mclk);
		arst_n <= 1;
		t_reset_caps();
		t_freeze_timing();
		t_timer_debug();
		t_test_modes();
		t_sleep();
		report_and_stop();
	end

	initial begin
		#400000;
		failures++;
		$display("BAD t=%0t got=%h exp=%h", $time, 0, 1);
		report_and_stop();
	end
endmodule // testbench
